// *** hw/rsc_pkg.sv ***
// constants for the clock/calendar control and event-steering block
package rsc_pkg;
  localparam logic [4:0] OFS_FLAGS = 5'h0e;
  localparam logic [4:0] OFS_CTRL = 5'h0f;
  localparam logic [4:0] OFS_RAM_ADDR = 5'h10;
  localparam logic [4:0] OFS_RAM_DATA = 5'h13;

  // flags_and_status bit positions
  localparam int unsigned BIT_ALARM_FLAG = 3;
  localparam int unsigned BIT_KEY_FLAG = 2;
  localparam int unsigned BIT_WDOG_FLAG = 1;
  localparam int unsigned BIT_IRQ_FLAG = 0;

  // event_enable_control bit positions
  localparam int unsigned BIT_TE = 7;
  localparam int unsigned BIT_XTAL = 6;
  localparam int unsigned BIT_BURST = 5;
  localparam int unsigned BIT_ALARM_WAKE = 4;
  localparam int unsigned BIT_ALARM_IE = 3;
  localparam int unsigned BIT_KEY_IE = 2;
  localparam int unsigned BIT_WDE = 1;
  localparam int unsigned BIT_WDS = 0;

  localparam logic [7:0] CTRL_RESET = 8'h80;
  localparam logic [3:0] FLAGS_RESET = 4'h0;
  localparam logic [7:0] RAM_ADDR_RESET = 8'h00;
  localparam int unsigned RAM_DEPTH = 256;

  // reset pulse length: least time, rounded up to whole cycles
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned RST_PULSE_MIN_MS = 40;
  localparam int unsigned RST_PULSE_MAX_MS = 200;
  localparam int unsigned RST_PULSE_CYC = (RST_PULSE_MIN_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage : rsc_pkg

// *** hw/rsc_pulse_if.sv ***
// handshake between the steering logic and the reset pulse timer
`timescale 1ns/1ns
`default_nettype none
interface rsc_pulse_if;
  logic start;
  logic active;
  modport ctrl (output start, input active);
  modport timer (input start, output active);
endinterface : rsc_pulse_if
`default_nettype wire

// *** hw/rsc_rst_pulse.sv ***
// one-shot reset pulse timer of fixed length
`timescale 1ns/1ns
`default_nettype none
module rsc_rst_pulse #(
  parameter int unsigned CYC = rsc_pkg::RST_PULSE_CYC
) (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  rsc_pulse_if.timer pulse
);
  logic [31:0] cnt_q;

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_q <= 32'h0;
      pulse.active <= 1'b0;
    end else if (ce_i) begin
      if (pulse.active) begin
        if (cnt_q == CYC - 1) begin
          pulse.active <= 1'b0;
          cnt_q <= 32'h0;
        end else begin
          cnt_q <= cnt_q + 32'h1;
        end
      end else if (pulse.start) begin
        // single pulse; a start while running is ignored
        pulse.active <= 1'b1;
        cnt_q <= 32'h0;
      end
    end
  end
endmodule : rsc_rst_pulse
`default_nettype wire

// *** hw/rsc_sync3.sv ***
// three-stage input synchroniser, output follows once stages two and three agree
`timescale 1ns/1ns
`default_nettype none
module rsc_sync3 #(
  parameter int unsigned W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic [W-1:0] d_i,
  output var logic [W-1:0] q_o
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s1_q <= RST_VAL;
      s2_q <= RST_VAL;
      s3_q <= RST_VAL;
    end else if (ce_i) begin
      s1_q <= d_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      q_o <= RST_VAL;
    end else if (ce_i) begin
      for (int i = 0; i < W; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          q_o[i] <= s3_q[i];
        end
      end
    end
  end
endmodule : rsc_sync3
`default_nettype wire

// *** hw/rsc_top.sv ***
// control and event-steering logic of a clock/calendar behind a byte-wide host bus
`timescale 1ns/1ns
`default_nettype none
module rsc_top #(
  parameter int unsigned RST_PULSE_CYC = rsc_pkg::RST_PULSE_CYC
) (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  // host bus pins
  input wire logic cs_n_i,
  input wire logic oe_n_i,
  input wire logic we_n_i,
  input wire logic [4:0] addr_i,
  input wire logic [7:0] dq_i,
  output var logic [7:0] dq_o,
  output var logic dq_oe_o,
  // pins from outside
  input wire logic wake_key_input_n_i,
  input wire logic main_supply_i,
  // events from timekeeping logic on this clock
  input wire logic alarm_match_i,
  input wire logic wdog_timeout_i,
  input wire logic second_tick_i,
  // open-drain outputs, pulled low while enable is high
  output var logic irq_n_oe_o,
  output var logic power_on_out_n_oe_o,
  output var logic rst_n_oe_o,
  // to timekeeping logic
  output var logic transfer_strobe_o,
  output var logic xtal_load_sel_o,
  output var logic wdog_kick_o,
  output var logic wdog_enable_o
);
  logic cs_n_s;
  logic oe_n_s;
  logic we_n_s;
  logic [4:0] addr_s;
  logic [7:0] dq_s;
  logic key_n_s;
  logic supply_s;

  rsc_sync3 #(.W(3), .RST_VAL(3'h7)) u_sync_strb (
    .clk_sys_i(clk_sys_i),
    .rst_b_i(rst_b_i),
    .ce_i(ce_i),
    .d_i({cs_n_i, oe_n_i, we_n_i}),
    .q_o({cs_n_s, oe_n_s, we_n_s})
  );

  rsc_sync3 #(.W(13), .RST_VAL(13'h0)) u_sync_bus (
    .clk_sys_i(clk_sys_i),
    .rst_b_i(rst_b_i),
    .ce_i(ce_i),
    .d_i({addr_i, dq_i}),
    .q_o({addr_s, dq_s})
  );

  rsc_sync3 #(.W(2), .RST_VAL(2'h3)) u_sync_pins (
    .clk_sys_i(clk_sys_i),
    .rst_b_i(rst_b_i),
    .ce_i(ce_i),
    .d_i({wake_key_input_n_i, main_supply_i}),
    .q_o({key_n_s, supply_s})
  );

  // registers
  logic alarm_match_flag_q;
  logic wake_key_flag_q;
  logic watchdog_timeout_flag_q;
  logic interrupt_request_flag_q;
  logic count_transfer_enable_q;
  logic xtal_sel_q;
  logic burst_increment_enable_q;
  logic alarm_wake_enable_q;
  logic alarm_int_enable_q;
  logic wake_key_int_enable_q;
  logic watchdog_enable_q;
  logic watchdog_steer_q;
  logic [7:0] ram_addr_q;
  logic [7:0] ram_q [rsc_pkg::RAM_DEPTH];

  // host bus: write taken on the rising edge of write strobe with chip select low
  logic we_n_p_q;
  logic [4:0] wr_addr_q;
  logic [7:0] wr_data_q;
  logic rd_act_p_q;
  logic [4:0] rd_addr_q;
  logic wr_go;
  logic rd_act;
  logic rd_end;
  logic wr_flags;
  logic wr_ctrl;
  logic wr_ram_addr;
  logic wr_ram_data;

  assign wr_go = !we_n_p_q && we_n_s && !cs_n_s;
  assign rd_act = !cs_n_s && !oe_n_s && we_n_s;
  assign rd_end = rd_act_p_q && !rd_act;
  assign wr_flags = wr_go && (wr_addr_q == rsc_pkg::OFS_FLAGS);
  assign wr_ctrl = wr_go && (wr_addr_q == rsc_pkg::OFS_CTRL);
  assign wr_ram_addr = wr_go && (wr_addr_q == rsc_pkg::OFS_RAM_ADDR);
  assign wr_ram_data = wr_go && (wr_addr_q == rsc_pkg::OFS_RAM_DATA);

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      we_n_p_q <= 1'b1;
      wr_addr_q <= 5'h00;
      wr_data_q <= 8'h00;
    end else if (ce_i) begin
      we_n_p_q <= we_n_s;
      // address and data held from the cycle before the strobe rises
      if (!we_n_s) begin
        wr_addr_q <= addr_s;
        wr_data_q <= dq_s;
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rd_act_p_q <= 1'b0;
      rd_addr_q <= 5'h00;
    end else if (ce_i) begin
      rd_act_p_q <= rd_act;
      if (rd_act) begin
        rd_addr_q <= addr_s;
      end
    end
  end

  // event_enable_control
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      count_transfer_enable_q <= rsc_pkg::CTRL_RESET[rsc_pkg::BIT_TE];
      xtal_sel_q <= rsc_pkg::CTRL_RESET[rsc_pkg::BIT_XTAL];
      burst_increment_enable_q <= rsc_pkg::CTRL_RESET[rsc_pkg::BIT_BURST];
      alarm_wake_enable_q <= rsc_pkg::CTRL_RESET[rsc_pkg::BIT_ALARM_WAKE];
      alarm_int_enable_q <= rsc_pkg::CTRL_RESET[rsc_pkg::BIT_ALARM_IE];
      wake_key_int_enable_q <= rsc_pkg::CTRL_RESET[rsc_pkg::BIT_KEY_IE];
      watchdog_steer_q <= rsc_pkg::CTRL_RESET[rsc_pkg::BIT_WDS];
    end else if (ce_i && wr_ctrl) begin
      count_transfer_enable_q <= wr_data_q[rsc_pkg::BIT_TE];
      xtal_sel_q <= wr_data_q[rsc_pkg::BIT_XTAL];
      burst_increment_enable_q <= wr_data_q[rsc_pkg::BIT_BURST];
      alarm_wake_enable_q <= wr_data_q[rsc_pkg::BIT_ALARM_WAKE];
      alarm_int_enable_q <= wr_data_q[rsc_pkg::BIT_ALARM_IE];
      wake_key_int_enable_q <= wr_data_q[rsc_pkg::BIT_KEY_IE];
      watchdog_steer_q <= wr_data_q[rsc_pkg::BIT_WDS];
    end
  end

  // watchdog enable, cleared by hardware once the reset pulse starts
  rsc_pulse_if pulse ();
  logic pulse_act_p_q;

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      watchdog_enable_q <= rsc_pkg::CTRL_RESET[rsc_pkg::BIT_WDE];
      pulse_act_p_q <= 1'b0;
    end else if (ce_i) begin
      pulse_act_p_q <= pulse.active;
      if (pulse.active && !pulse_act_p_q) begin
        watchdog_enable_q <= 1'b0;
      end else if (wr_ctrl) begin
        watchdog_enable_q <= wr_data_q[rsc_pkg::BIT_WDE];
      end
    end
  end

  // reset pulse only for a timeout with watchdog active and steered to reset
  assign pulse.start = wdog_timeout_i && watchdog_enable_q && watchdog_steer_q;

  rsc_rst_pulse #(.CYC(RST_PULSE_CYC)) u_rst_pulse (
    .clk_sys_i(clk_sys_i),
    .rst_b_i(rst_b_i),
    .ce_i(ce_i),
    .pulse(pulse)
  );

  // sticky flags: a hardware set wins over a clearing write
  logic key_n_p_q;
  logic key_event;

  assign key_event = key_n_p_q && !key_n_s;

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      key_n_p_q <= 1'b1;
    end else if (ce_i) begin
      key_n_p_q <= key_n_s;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      alarm_match_flag_q <= rsc_pkg::FLAGS_RESET[rsc_pkg::BIT_ALARM_FLAG];
    end else if (ce_i) begin
      if (alarm_match_i) begin
        alarm_match_flag_q <= 1'b1;
      end else if (wr_flags && !wr_data_q[rsc_pkg::BIT_ALARM_FLAG]) begin
        alarm_match_flag_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wake_key_flag_q <= rsc_pkg::FLAGS_RESET[rsc_pkg::BIT_KEY_FLAG];
    end else if (ce_i) begin
      if (key_event) begin
        wake_key_flag_q <= 1'b1;
      end else if (wr_flags) begin
        wake_key_flag_q <= wr_data_q[rsc_pkg::BIT_KEY_FLAG];
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      watchdog_timeout_flag_q <= rsc_pkg::FLAGS_RESET[rsc_pkg::BIT_WDOG_FLAG];
    end else if (ce_i) begin
      if (wdog_timeout_i) begin
        watchdog_timeout_flag_q <= 1'b1;
      end else if (wr_flags && !wr_data_q[rsc_pkg::BIT_WDOG_FLAG]) begin
        watchdog_timeout_flag_q <= 1'b0;
      end
    end
  end

  // request flag: recomputed every cycle, never written
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      interrupt_request_flag_q <= rsc_pkg::FLAGS_RESET[rsc_pkg::BIT_IRQ_FLAG];
    end else if (ce_i) begin
      interrupt_request_flag_q <= (alarm_match_flag_q && alarm_int_enable_q)
        || (wake_key_flag_q && wake_key_int_enable_q)
        || (watchdog_timeout_flag_q && watchdog_enable_q);
    end
  end

  // pin drivers
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      irq_n_oe_o <= 1'b0;
      power_on_out_n_oe_o <= 1'b0;
      rst_n_oe_o <= 1'b0;
    end else if (ce_i) begin
      // irq waits for main supply
      irq_n_oe_o <= interrupt_request_flag_q && supply_s;
      power_on_out_n_oe_o <= (alarm_match_flag_q && alarm_wake_enable_q)
        || (wake_key_flag_q && wake_key_int_enable_q);
      rst_n_oe_o <= pulse.active;
    end
  end

  // outputs to the timekeeping logic
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      transfer_strobe_o <= 1'b0;
      xtal_load_sel_o <= 1'b0;
      wdog_kick_o <= 1'b0;
      wdog_enable_o <= 1'b0;
    end else if (ce_i) begin
      transfer_strobe_o <= second_tick_i && count_transfer_enable_q;
      xtal_load_sel_o <= xtal_sel_q;
      wdog_kick_o <= wr_go;
      wdog_enable_o <= watchdog_enable_q;
    end
  end

  // extended RAM address and data
  logic ram_data_done;

  assign ram_data_done = wr_ram_data || (rd_end && rd_addr_q == rsc_pkg::OFS_RAM_DATA);

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ram_addr_q <= rsc_pkg::RAM_ADDR_RESET;
    end else if (ce_i) begin
      if (wr_ram_addr) begin
        ram_addr_q <= wr_data_q;
      end else if (ram_data_done && burst_increment_enable_q) begin
        ram_addr_q <= ram_addr_q + 8'h01;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (ce_i && wr_ram_data) begin
      ram_q[ram_addr_q] <= wr_data_q;
    end
  end

  // read data
  logic [7:0] rd_mux;

  always_comb begin
    case (addr_s)
      rsc_pkg::OFS_FLAGS: begin
        rd_mux = {4'h0, alarm_match_flag_q, wake_key_flag_q, watchdog_timeout_flag_q, interrupt_request_flag_q};
      end
      rsc_pkg::OFS_CTRL: begin
        rd_mux = {count_transfer_enable_q, xtal_sel_q, burst_increment_enable_q, alarm_wake_enable_q,
                  alarm_int_enable_q, wake_key_int_enable_q, watchdog_enable_q, watchdog_steer_q};
      end
      rsc_pkg::OFS_RAM_ADDR: begin
        rd_mux = ram_addr_q;
      end
      rsc_pkg::OFS_RAM_DATA: begin
        rd_mux = ram_q[ram_addr_q];
      end
      default: begin
        rd_mux = 8'h00;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      dq_o <= 8'h00;
      dq_oe_o <= 1'b0;
    end else if (ce_i) begin
      dq_oe_o <= rd_act;
      dq_o <= rd_act ? rd_mux : 8'h00;
    end
  end
endmodule : rsc_top
`default_nettype wire

// *** sim/rsc_checker.sv ***
// concurrent checks on the pins of the event-steering block
`timescale 1ns/1ns
`default_nettype none
module rsc_checker #(
  parameter int unsigned RST_PULSE_CYC = rsc_pkg::RST_PULSE_CYC
) (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic cs_n_i,
  input wire logic oe_n_i,
  input wire logic we_n_i,
  input wire logic main_supply_i,
  input wire logic wdog_timeout_i,
  input wire logic second_tick_i,
  input wire logic dq_oe_o,
  input wire logic irq_n_oe_o,
  input wire logic rst_n_oe_o,
  input wire logic transfer_strobe_o,
  input wire logic xtal_load_sel_o,
  input wire logic wdog_kick_o,
  input wire logic wdog_enable_o
);
  logic [31:0] pulse_cnt_q;
  logic [3:0] rd_cnt_q;
  logic [3:0] idle_cnt_q;
  logic [3:0] sup_lo_q;
  logic [3:0] wr_age_q;
  wire logic rd_pins = !cs_n_i && !oe_n_i && we_n_i;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);
  // length of the running reset pulse
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) pulse_cnt_q <= '0;
    else if (!rst_n_oe_o) pulse_cnt_q <= '0;
    else if (ce_i) pulse_cnt_q <= pulse_cnt_q + 32'h1;
  end
  // saturating ages of read strobes at the pins
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rd_cnt_q <= 4'h0;
      idle_cnt_q <= 4'h0;
    end else begin
      rd_cnt_q <= !rd_pins ? 4'h0 : (rd_cnt_q == 4'hf ? rd_cnt_q : rd_cnt_q + 4'h1);
      idle_cnt_q <= rd_pins ? 4'h0 : (idle_cnt_q == 4'hf ? idle_cnt_q : idle_cnt_q + 4'h1);
    end
  end
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) sup_lo_q <= 4'h0;
    else if (main_supply_i) sup_lo_q <= 4'h0;
    else if (sup_lo_q != 4'hf) sup_lo_q <= sup_lo_q + 4'h1;
  end
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) wr_age_q <= 4'hf;
    else if (!cs_n_i && !we_n_i) wr_age_q <= 4'h0;
    else if (wr_age_q != 4'hf) wr_age_q <= wr_age_q + 4'h1;
  end
  AST_PULSE_LEN: assert property ($fell(rst_n_oe_o) |-> pulse_cnt_q == RST_PULSE_CYC)
    else $error("reset pulse length wrong");
  AST_PULSE_CAUSE: assert property ($rose(rst_n_oe_o) |-> $past(wdog_timeout_i, 2) || $past(wdog_timeout_i, 3))
    else $error("reset pulse without timeout");
  AST_WDE_CLEAR: assert property ($rose(rst_n_oe_o) |-> ##[0:2] !wdog_enable_o)
    else $error("watchdog enable kept");
  AST_XFER_GATE: assert property (transfer_strobe_o |-> $past(second_tick_i))
    else $error("transfer without tick");
  AST_XTAL_SW: assert property ($changed(xtal_load_sel_o) |-> wdog_kick_o || $past(wdog_kick_o))
    else $error("crystal select moved without write");
  AST_WDE_SW: assert property ($rose(wdog_enable_o) |-> wdog_kick_o || $past(wdog_kick_o))
    else $error("watchdog enabled without write");
  AST_KICK_WRITE: assert property (wdog_kick_o |-> wr_age_q <= 4'h7)
    else $error("kick without host write");
  AST_KICK_DUE: assert property ($rose(we_n_i) && !cs_n_i |-> ##[3:7] wdog_kick_o)
    else $error("host write gave no kick");
  AST_READ_DRIVE: assert property (rd_cnt_q >= 4'h6 |-> dq_oe_o)
    else $error("read not driven");
  AST_READ_RELEASE: assert property (idle_cnt_q >= 4'h6 |-> !dq_oe_o)
    else $error("data bus not released");
  AST_IRQ_SUPPLY: assert property (sup_lo_q >= 4'h6 |-> !irq_n_oe_o)
    else $error("interrupt pin pulled without supply");
endmodule : rsc_checker
bind rsc_top rsc_checker #(.RST_PULSE_CYC(RST_PULSE_CYC)) u_chk (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
  .ce_i(ce_i), .cs_n_i(cs_n_i), .oe_n_i(oe_n_i), .we_n_i(we_n_i), .main_supply_i(main_supply_i),
  .wdog_timeout_i(wdog_timeout_i), .second_tick_i(second_tick_i), .dq_oe_o(dq_oe_o), .irq_n_oe_o(irq_n_oe_o),
  .rst_n_oe_o(rst_n_oe_o), .transfer_strobe_o(transfer_strobe_o), .xtal_load_sel_o(xtal_load_sel_o),
  .wdog_kick_o(wdog_kick_o), .wdog_enable_o(wdog_enable_o));
`default_nettype wire

// *** sim/rsc_host_model.sv ***
// host processor model on the byte-wide asynchronous register bus
`timescale 1ns/1ns
`default_nettype none
module rsc_host_model (
  input wire logic clk_sys_i,
  input wire logic [7:0] dq_i,
  output var logic cs_n_o,
  output var logic oe_n_o,
  output var logic we_n_o,
  output var logic [4:0] addr_o,
  output var logic [7:0] dq_o
);
  initial begin
    cs_n_o = 1'b1;
    oe_n_o = 1'b1;
    we_n_o = 1'b1;
    addr_o = 5'h1f;
    dq_o = 8'h00;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask : hold
  // zero writes clear flags; transfer enable off freezes user counts
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    cs_n_o = 1'b0;
    we_n_o = 1'b0;
    addr_o = a;
    dq_o = d;
    hold(5);
    we_n_o = 1'b1;
    hold(5);
    cs_n_o = 1'b1;
    addr_o = ~a;
    dq_o = ~d;
    hold(5);
  endtask : wr
  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    cs_n_o = 1'b0;
    oe_n_o = 1'b0;
    addr_o = a;
    hold(6);
    d = dq_i;
    oe_n_o = 1'b1;
    hold(1);
    cs_n_o = 1'b1;
    addr_o = ~a;
    hold(5);
  endtask : rd
endmodule : rsc_host_model
`default_nettype wire

// *** sim/tb_rtc_event_steering_control.sv ***
// self-checking bench for the event-steering block
`timescale 1ns/1ns
`default_nettype none
module tb_rtc_event_steering_control;
  localparam int unsigned PCYC = 20;
  logic clk_sys_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic wake_n = 1'b1;
  logic supply = 1'b1;
  logic ce = 1'b1;
  logic [2:0] ev = 3'h0;
  logic cs_n, oe_n, we_n, dq_oe, irq, power_on_out_n, rst_oe, strobe, xtal, kick, watchdog_enable;
  logic [4:0] addr;
  logic [7:0] dq_w, dq_r;
  int miscompares = 0;
  int num_checks = 0;
  always #5 clk_sys_i = ~clk_sys_i;
  rsc_host_model u_host (.clk_sys_i(clk_sys_i), .dq_i(dq_r), .cs_n_o(cs_n), .oe_n_o(oe_n), .we_n_o(we_n),
    .addr_o(addr), .dq_o(dq_w));
  rsc_top #(.RST_PULSE_CYC(PCYC)) DUT (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .ce_i(ce), .cs_n_i(cs_n),
    .oe_n_i(oe_n), .we_n_i(we_n), .addr_i(addr), .dq_i(dq_w), .dq_o(dq_r), .dq_oe_o(dq_oe),
    .wake_key_input_n_i(wake_n), .main_supply_i(supply), .alarm_match_i(ev[0]), .wdog_timeout_i(ev[1]),
    .second_tick_i(ev[2]), .irq_n_oe_o(irq), .power_on_out_n_oe_o(power_on_out_n), .rst_n_oe_o(rst_oe),
    .transfer_strobe_o(strobe), .xtal_load_sel_o(xtal), .wdog_kick_o(kick), .wdog_enable_o(watchdog_enable));
  task automatic print_verdict;
    if (miscompares == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : print_verdict
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask : cyc
  task automatic pulse(input logic [2:0] m);
    cyc(1);
    ev = m;
    cyc(1);
    ev = 3'h0;
  endtask : pulse
  task automatic key_pulse;
    wake_n = 1'b0;
    cyc(6);
    wake_n = 1'b1;
    cyc(6);
  endtask : key_pulse
  task automatic rd_chk(input logic [4:0] a, input logic [7:0] exp);
    logic [7:0] d;
    u_host.rd(a, d);
    check(d, exp);
  endtask : rd_chk
  task automatic pins(input logic [2:0] exp);
    check({5'h0, irq, power_on_out_n, rst_oe}, {5'h0, exp});
  endtask : pins
  task automatic ctl(input logic [7:0] d);
    u_host.wr(rsc_pkg::OFS_CTRL, d);
  endtask : ctl
  task automatic flg(input logic [7:0] d);
    u_host.wr(rsc_pkg::OFS_FLAGS, d);
  endtask : flg
  task automatic t_reset;
    rd_chk(rsc_pkg::OFS_CTRL, rsc_pkg::CTRL_RESET);
    flg(8'h01);
    u_host.wr(5'h11, 8'h5a);
    rd_chk(rsc_pkg::OFS_FLAGS, 8'h00);
    rd_chk(5'h11, 8'h00);
    pins(3'h0);
  endtask : t_reset
  task automatic t_transfer;
    pulse(3'h4);
    check({7'h0, strobe}, 8'h01);
    cyc(1);
    // clock enable low: a tick must leave the transfer strobe frozen
    ce = 1'b0;
    pulse(3'h4);
    check({7'h0, strobe}, 8'h00);
    ce = 1'b1;
    ctl(8'h00);
    pulse(3'h4);
    check({7'h0, strobe}, 8'h00);
    rd_chk(rsc_pkg::OFS_CTRL, 8'h00);
    ctl(8'hc0);
    check({7'h0, xtal}, 8'h01);
    ctl(8'h80);
    check({7'h0, xtal}, 8'h00);
  endtask : t_transfer
  task automatic t_alarm;
    ctl(8'h88);
    pulse(3'h1);
    cyc(3);
    pins(3'h4);
    rd_chk(rsc_pkg::OFS_FLAGS, 8'h09);
    ctl(8'h98);
    pins(3'h6);
    flg(8'h00);
    pins(3'h0);
    ctl(8'h80);
    pulse(3'h1);
    cyc(3);
    pins(3'h0);
    rd_chk(rsc_pkg::OFS_FLAGS, 8'h08);
    flg(8'h00);
  endtask : t_alarm
  task automatic t_key;
    key_pulse();
    rd_chk(rsc_pkg::OFS_FLAGS, 8'h04);
    pins(3'h0);
    flg(8'h00);
    ctl(8'h84);
    supply = 1'b0;
    cyc(6);
    key_pulse();
    pins(3'h2);
    supply = 1'b1;
    cyc(6);
    pins(3'h6);
    flg(8'h00);
    pins(3'h0);
    key_pulse();
    pins(3'h6);
    flg(8'h00);
    flg(8'h04);
    rd_chk(rsc_pkg::OFS_FLAGS, 8'h05);
    flg(8'h00);
    ctl(8'h80);
  endtask : t_key
  task automatic t_wdog_irq;
    ctl(8'h82);
    pulse(3'h2);
    cyc(3);
    pins(3'h4);
    rd_chk(rsc_pkg::OFS_FLAGS, 8'h03);
    flg(8'h00);
    pins(3'h0);
    ctl(8'h80);
    pulse(3'h2);
    cyc(3);
    pins(3'h0);
    rd_chk(rsc_pkg::OFS_FLAGS, 8'h02);
    flg(8'h00);
  endtask : t_wdog_irq
  task automatic t_wdog_rst;
    int n;
    ctl(8'h83);
    pulse(3'h2);
    n = 0;
    while (rst_oe !== 1'b1 && n < 5) begin
      cyc(1);
      n++;
    end
    check({7'h0, rst_oe}, 8'h01);
    cyc(1);
    check({7'h0, irq}, 8'h01);
    n = 1;
    while (rst_oe === 1'b1 && n < 400) begin
      cyc(1);
      n++;
    end
    check(8'(n), 8'(PCYC));
    check({7'h0, watchdog_enable}, 8'h00);
    rd_chk(rsc_pkg::OFS_CTRL, 8'h81);
    rd_chk(rsc_pkg::OFS_FLAGS, 8'h02);
    flg(8'h00);
    ctl(8'h80);
  endtask : t_wdog_rst
  task automatic t_burst;
    u_host.wr(rsc_pkg::OFS_RAM_ADDR, 8'hfe);
    ctl(8'ha0);
    u_host.wr(rsc_pkg::OFS_RAM_DATA, 8'h11);
    u_host.wr(rsc_pkg::OFS_RAM_DATA, 8'h22);
    rd_chk(rsc_pkg::OFS_RAM_ADDR, 8'h00);
    u_host.wr(rsc_pkg::OFS_RAM_ADDR, 8'hfe);
    rd_chk(rsc_pkg::OFS_RAM_DATA, 8'h11);
    rd_chk(rsc_pkg::OFS_RAM_DATA, 8'h22);
    ctl(8'h80);
    u_host.wr(rsc_pkg::OFS_RAM_DATA, 8'h33);
    rd_chk(rsc_pkg::OFS_RAM_DATA, 8'h33);
    rd_chk(rsc_pkg::OFS_RAM_ADDR, 8'h00);
  endtask : t_burst
  initial begin
    cyc(3);
    rst_b_i = 1'b1;
    t_reset();
    t_transfer();
    t_alarm();
    t_key();
    t_wdog_irq();
    t_wdog_rst();
    t_burst();
    print_verdict();
  end
  // cut a hang short
  initial begin
    #200000;
    miscompares++;
    print_verdict();
  end
endmodule : tb_rtc_event_steering_control
`default_nettype wire
